// ==== logic/blsl_pkg.sv ====
package blsl_pkg;
    localparam logic [7:0] OFF_STYLE = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_ERR0 = 8'h08;
    localparam logic [7:0] OFF_ERR1 = 8'h0c;
    localparam logic [7:0] OFF_LAUNCH = 8'h10;
    localparam logic [7:0] OFF_STRETCH = 8'h14;
    localparam logic [7:0] OFF_CMD = 8'h18;
    localparam logic [7:0] OFF_SRCPOS = 8'h1c;
    localparam logic [7:0] OFF_DSTPOS = 8'h20;
    localparam logic [7:0] OFF_LAYOUT = 8'h24;
    localparam logic [7:0] OFF_FORE = 8'h28;
    localparam logic [7:0] OFF_BACK = 8'h2c;
    localparam logic [7:0] OFF_EXTENT = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h34;
    localparam int REP_LSB = 0;
    localparam int LEN_LSB = 8;
    localparam int FRAC_LSB = 16;
    localparam int INT_LSB = 24;
    localparam int ERR_USE_BIT = 31;
    localparam int CMD_TRANSP_BIT = 16;
    localparam int CMD_XDIR_BIT = 14;
    localparam int CMD_YDIR_BIT = 15;
    localparam logic [3:0] MODE_NOP = 4'h0;
    localparam logic [3:0] MODE_SCREEN = 4'h1;
    localparam logic [3:0] MODE_STRETCH = 4'h2;
    localparam logic [3:0] MODE_HOST = 4'h3;
    localparam logic [3:0] MODE_LINE = 4'h6;
    localparam logic [3:0] FMT_MONO = 4'h0;
    localparam logic [31:0] XY_MASK = 32'h1fff1fff;
    localparam logic [31:0] STYLE_MASK = 32'h1fff1fff;
    localparam logic [31:0] ERR_MASK = 32'h8000ffff;
    localparam int HOLD_DEPTH = 4;
    typedef enum logic [3:0] {
        BLSL_IDLE = 4'b0001,
        BLSL_LINE = 4'b0010,
        BLSL_COPY = 4'b0100,
        BLSL_HOST = 4'b1000
    } blsl_state_t;
endpackage

// ==== logic/blsl_engine.sv ====
// What this block does
// - pattern length field is bits used minus one
// - repeat field is pixels per bit minus one
// - first bit covers repeat+1 minus fraction pixels
// - mask bits indexed lsb zero to msb 31
// - style write loads working stipple position
// - unwritten style keeps position across lines
// - idle style read returns next position
// - set bit foreground, clear background or skip
// - fraction counts to repeat, index wraps at length
// - mask bits above length are ignored
// - style fields at 7:0, 12:8, 23:16, 28:24
// - error bit 31 selects programmed term
// - error0 lines, left, vertical; error1 right, horizontal
// - screen copy launch loads source position
// - stretch launch loads source, ignores direction
// - host mode takes launch words as pixels
// - host first bit or byte from source low bits
// - next span alignment adds source stride
// - surplus host data stays queued and starts the next host run
// - line launch loads destination, then copies back
`timescale 1ns/1ps
`default_nettype none
module blsl_engine
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic pixelReady,
    output logic pixelValid,
    output logic pixelWrite,
    output logic [31:0] pixelColour,
    output logic busy,
    output logic copyStart,
    output logic [31:0] copySource,
    output logic copyTopDownLtr,
    output logic hostWordValid,
    output logic [31:0] hostWord,
    output logic [4:0] hostAlign,
    output logic hostAbort,
    output logic [15:0] errVertical,
    output logic [15:0] errHorizontal,
    output logic errVerticalUse,
    output logic errHorizontalUse
);
    import blsl_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic [31:0] style, mask, err0, err1, cmd, srcPos, dstPos, layout;
    logic [31:0] fore, back, extent;
    logic [7:0] fracPos;
    logic [4:0] bitPos;
    logic styleWritten;
    blsl_state_t state;
    logic [15:0] pixLeft;
    logic [15:0] wordsLeft;
    logic [35:0] holdMem [HOLD_DEPTH];
    logic [1:0] holdWr, holdRd;
    logic [2:0] holdCnt;
    logic [4:0] spanAlign;

    wire logic [3:0] mode = cmd[3:0];
    wire logic [7:0] repCnt = style[REP_LSB +: 8];
    wire logic [4:0] patLen = style[LEN_LSB +: 5];
    wire logic wrStyle = regWr && hit(regAddr, OFF_STYLE);
    wire logic wrLaunch = regWr && (hit(regAddr, OFF_LAUNCH) || hit(regAddr, OFF_STRETCH));
    // one write strobe per register
    wire logic wrMask = regWr && hit(regAddr, OFF_MASK);
    wire logic wrErr0 = regWr && hit(regAddr, OFF_ERR0);
    wire logic wrErr1 = regWr && hit(regAddr, OFF_ERR1);
    wire logic wrCmd = regWr && hit(regAddr, OFF_CMD);
    wire logic wrSrcPos = regWr && hit(regAddr, OFF_SRCPOS);
    wire logic wrDstPos = regWr && hit(regAddr, OFF_DSTPOS);
    wire logic wrLayout = regWr && hit(regAddr, OFF_LAYOUT);
    wire logic wrFore = regWr && hit(regAddr, OFF_FORE);
    wire logic wrBack = regWr && hit(regAddr, OFF_BACK);
    wire logic wrExtent = regWr && hit(regAddr, OFF_EXTENT);
    wire logic isMono = layout[19:16] == FMT_MONO;
    wire logic holdFull = holdCnt == 3'(HOLD_DEPTH);
    wire logic holdEmpty = holdCnt == 3'd0;
    wire logic [35:0] holdHead = holdMem[holdRd];
    wire logic [3:0] headMode = holdHead[35:32];
    wire logic [31:0] holdWord = holdHead[31:0];
    wire logic pixStep = state == BLSL_LINE && pixelReady;
    wire logic lineLast = pixStep && pixLeft == 16'd0;
    wire logic hostStep = state == BLSL_HOST && !holdEmpty;
    wire logic hostLast = hostStep && wordsLeft == 16'd1;
    wire logic startOp = state == BLSL_IDLE && !holdEmpty;
    wire logic startLine = startOp && headMode == MODE_LINE;
    wire logic startHost = startOp && headMode == MODE_HOST;
    // a host word stays queued at start so that it is also sent as data
    wire logic pop = (startOp && !startHost) || hostStep;
    wire logic push = wrLaunch && !holdFull && mode != MODE_NOP;
    wire logic patBit = mask[bitPos];
    wire logic endRun = fracPos == repCnt;
    wire logic endPat = bitPos >= patLen;
    wire logic [4:0] nextBitPos = endRun ? (endPat ? 5'd0 : bitPos + 5'd1) : bitPos;
    wire logic [7:0] nextFracPos = endRun ? 8'd0 : fracPos + 8'd1;
    // length comes from the launch word on the start cycle itself
    wire logic [31:0] lineEnd = startLine ? holdWord & XY_MASK : dstPos;
    wire logic [15:0] dx = lineEnd[15:0] > srcPos[15:0] ? lineEnd[15:0] - srcPos[15:0]
        : srcPos[15:0] - lineEnd[15:0];
    wire logic [15:0] dy = lineEnd[31:16] > srcPos[31:16] ? lineEnd[31:16] - srcPos[31:16]
        : srcPos[31:16] - lineEnd[31:16];
    wire logic [15:0] lineLen = dx > dy ? dx : dy;
    wire logic [4:0] firstAlign = isMono ? srcPos[4:0] : {3'd0, srcPos[1:0]};
    wire logic [4:0] nextAlign = isMono ? spanAlign + layout[4:0]
        : {3'd0, spanAlign[1:0] + layout[1:0]};
    wire logic [31:0] styleRead = {3'd0, bitPos, fracPos, style[15:0]};

    // read selection; unmapped offsets read as zero
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        case (regAddr)
            OFF_STYLE: rdMux = styleRead;
            OFF_MASK: rdMux = mask;
            OFF_ERR0: rdMux = err0;
            OFF_ERR1: rdMux = err1;
            OFF_CMD: rdMux = cmd;
            OFF_SRCPOS: rdMux = srcPos;
            OFF_DSTPOS: rdMux = dstPos;
            OFF_LAYOUT: rdMux = layout;
            OFF_FORE: rdMux = fore;
            OFF_BACK: rdMux = back;
            OFF_EXTENT: rdMux = extent;
            OFF_STATUS: rdMux = {27'd0, styleWritten, holdCnt, state != BLSL_IDLE};
            default: rdMux = 32'h0;
        endcase
    end

    // launch words are tagged by the mode active when written
    always_ff @(posedge clk) begin
        if (push) begin
            holdMem[holdWr] <= {mode, regWrData};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            holdWr <= 2'd0;
            holdRd <= 2'd0;
            holdCnt <= 3'd0;
        end else begin
            if (push) begin
                holdWr <= holdWr + 2'd1;
            end
            if (pop) begin
                holdRd <= holdRd + 2'd1;
            end
            holdCnt <= holdCnt + 3'(push) - 3'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            style <= 32'h0;
            mask <= 32'h0;
        end else begin
            if (wrStyle) begin
                style <= regWrData & STYLE_MASK;
            end
            if (wrMask) begin
                mask <= regWrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            err0 <= 32'h0;
            err1 <= 32'h0;
        end else begin
            if (wrErr0) begin
                err0 <= regWrData & ERR_MASK;
            end
            if (wrErr1) begin
                err1 <= regWrData & ERR_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd <= 32'h0;
            layout <= 32'h0;
            extent <= 32'h0;
        end else begin
            if (wrCmd) begin
                cmd <= regWrData;
            end
            if (wrLayout) begin
                layout <= regWrData;
            end
            if (wrExtent) begin
                extent <= regWrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fore <= 32'h0;
            back <= 32'h0;
        end else begin
            if (wrFore) begin
                fore <= regWrData;
            end
            if (wrBack) begin
                back <= regWrData;
            end
        end
    end

    // stipple position: loaded on style write, otherwise carried over
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bitPos <= 5'd0;
            fracPos <= 8'd0;
            styleWritten <= 1'b0;
        end else if (wrStyle) begin
            bitPos <= regWrData[INT_LSB +: 5];
            fracPos <= regWrData[FRAC_LSB +: 8];
            styleWritten <= 1'b1;
        end else if (pixStep) begin
            bitPos <= nextBitPos;
            fracPos <= nextFracPos;
            styleWritten <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= BLSL_IDLE;
            srcPos <= 32'h0;
            dstPos <= 32'h0;
            wordsLeft <= 16'd0;
            spanAlign <= 5'd0;
        end else begin
            if (wrSrcPos) begin
                srcPos <= regWrData & XY_MASK;
            end
            if (wrDstPos) begin
                dstPos <= regWrData & XY_MASK;
            end
            case (state)
                BLSL_IDLE: begin
                    if (startOp) begin
                        case (headMode)
                            MODE_LINE: begin
                                dstPos <= holdWord & XY_MASK;
                                state <= BLSL_LINE;
                            end
                            MODE_SCREEN, MODE_STRETCH: begin
                                srcPos <= holdWord & XY_MASK;
                                state <= BLSL_COPY;
                            end
                            MODE_HOST: begin
                                wordsLeft <= extent[31:16] == 16'd0 ? 16'd1 : extent[31:16];
                                spanAlign <= firstAlign;
                                state <= BLSL_HOST;
                            end
                            default: state <= BLSL_IDLE;
                        endcase
                    end
                end
                BLSL_LINE: begin
                    if (lineLast) begin
                        srcPos <= dstPos;
                        state <= BLSL_IDLE;
                    end
                end
                BLSL_COPY: state <= BLSL_IDLE;
                BLSL_HOST: begin
                    if (hostStep) begin
                        spanAlign <= nextAlign;
                        wordsLeft <= wordsLeft - 16'd1;
                        if (hostLast) begin
                            state <= BLSL_IDLE;
                        end
                    end
                end
                default: state <= BLSL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || state != BLSL_LINE) begin
            pixLeft <= lineLen;
        end else if (pixStep) begin
            pixLeft <= pixLeft - 16'd1;
        end
    end

    // pixel stream to the drawing back end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pixelValid <= 1'b0;
            pixelWrite <= 1'b0;
            pixelColour <= 32'h0;
        end else begin
            pixelValid <= pixStep;
            pixelWrite <= pixStep && (patBit || !cmd[CMD_TRANSP_BIT]);
            pixelColour <= patBit ? fore : back;
        end
    end

    // copy start towards the rectangle mover
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            copyStart <= 1'b0;
            copySource <= 32'h0;
            copyTopDownLtr <= 1'b0;
        end else begin
            copyStart <= state == BLSL_COPY;
            copySource <= srcPos;
            copyTopDownLtr <= mode == MODE_STRETCH
                || (!cmd[CMD_XDIR_BIT] && !cmd[CMD_YDIR_BIT]);
        end
    end

    // host words with their span alignment
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hostWordValid <= 1'b0;
            hostWord <= 32'h0;
            hostAlign <= 5'd0;
            hostAbort <= 1'b0;
        end else begin
            hostWordValid <= hostStep;
            hostWord <= holdWord;
            hostAlign <= spanAlign;
            hostAbort <= state == BLSL_HOST && mode != MODE_HOST;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy <= 1'b0;
            regRdData <= 32'h0;
        end else begin
            busy <= state != BLSL_IDLE || !holdEmpty;
            regRdData <= regRd ? rdMux : 32'h0;
        end
    end

    // error seeds: zero use flag means the engines compute their own
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            errVertical <= 16'd0;
            errHorizontal <= 16'd0;
            errVerticalUse <= 1'b0;
            errHorizontalUse <= 1'b0;
        end else begin
            errVertical <= err0[15:0];
            errHorizontal <= err1[15:0];
            errVerticalUse <= err0[ERR_USE_BIT];
            errHorizontalUse <= err1[ERR_USE_BIT];
        end
    end
endmodule
`default_nettype wire

// ==== sim/blsl_engine_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module blsl_engine_sva
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic pixelReady,
    input wire logic pixelValid,
    input wire logic pixelWrite,
    input wire logic [31:0] pixelColour,
    input wire logic busy,
    input wire logic copyStart,
    input wire logic [31:0] copySource,
    input wire logic copyTopDownLtr,
    input wire logic [15:0] errVertical,
    input wire logic [15:0] errHorizontal,
    input wire logic errVerticalUse,
    input wire logic errHorizontalUse
);
    import blsl_pkg::*;
    logic [31:0] cmd, fore, back, mask;
    // shadows of the registers the pixel, copy and mask readback checks depend on
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd <= 32'h0;
            fore <= 32'h0;
            back <= 32'h0;
            mask <= 32'h0;
        end else if (regWr) begin
            case (regAddr)
                OFF_CMD: cmd <= regWrData;
                OFF_FORE: fore <= regWrData;
                OFF_BACK: back <= regWrData;
                OFF_MASK: mask <= regWrData;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data not zero outside read slot");
    a_mask_readback: assert property ($past(regRd && regAddr == OFF_MASK) |-> regRdData == mask)
        else $error("dash mask readback differs");
    a_err_vert_seed: assert property ($past(regWr && regAddr == OFF_ERR0, 2) |->
        {errVerticalUse, errVertical} ==
        {$past(regWrData[31], 2), $past(regWrData[15:0], 2)})
        else $error("vertical seed not taken from write");
    a_err_horiz_seed: assert property ($past(regWr && regAddr == OFF_ERR1, 2) |->
        {errHorizontalUse, errHorizontal} ==
        {$past(regWrData[31], 2), $past(regWrData[15:0], 2)})
        else $error("horizontal seed not taken from write");
    a_copy_launch: assert property (regWr && !busy &&
        (regAddr == OFF_LAUNCH || regAddr == OFF_STRETCH) &&
        (cmd[3:0] == MODE_SCREEN || cmd[3:0] == MODE_STRETCH) |->
        ##3 (copyStart && copySource == ($past(regWrData, 3) & XY_MASK)))
        else $error("copy launch not started with source");
    a_copy_order: assert property (copyStart |-> copyTopDownLtr ==
        (cmd[3:0] == MODE_STRETCH || cmd[CMD_YDIR_BIT:CMD_XDIR_BIT] == 2'b00))
        else $error("copy direction wrong");
    a_pix_ready: assert property (pixelValid |-> $past(pixelReady))
        else $error("pixel issued without ready");
    a_pix_opaque: assert property (pixelValid && !cmd[CMD_TRANSP_BIT] |-> pixelWrite)
        else $error("opaque pixel skipped");
    a_pix_colour: assert property (pixelValid && pixelWrite |-> pixelColour == fore ||
        (!cmd[CMD_TRANSP_BIT] && pixelColour == back))
        else $error("pixel colour not fore or back");
endmodule
bind blsl_engine blsl_engine_sva chk (.*);
`default_nettype wire

// ==== sim/blsl_engine_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module blsl_engine_tb_top;
    import blsl_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, pixelReady = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, pixelColour, copySource, hostWord;
    logic pixelValid, pixelWrite, busy, copyStart, copyTopDownLtr, hostWordValid, hostAbort;
    logic errVerticalUse, errHorizontalUse;
    logic [4:0] hostAlign, idx;
    logic [15:0] errVertical, errHorizontal;
    logic [7:0] frac;
    logic stall = 1'b0, transp = 1'b0;
    logic [31:0] style = 32'h07020904, msk = 32'hfffffeb7;
    logic [31:0] hw [2] = '{32'hc0608020, 32'hc460c060};
    int errors = 0;
    int n_compared = 0;
    blsl_engine dut (.*);
    always #10 clk = ~clk;
    always @(posedge clk) pixelReady <= stall ? ~pixelReady : 1'b1;
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask
    // launches a line and checks every pixel against the stipple walk
    task automatic draw(input logic [31:0] dst, input int n);
        int got;
        logic b;
        got = 0;
        wr(OFF_LAUNCH, dst);
        for (int c = 0; c < 500 && got < n; c++) begin
            @(negedge clk);
            if (pixelValid === 1'b1) begin
                b = msk[idx];
                `CHK("pixel write", b | ~transp, pixelWrite)
                if (b | ~transp) `CHK("pixel colour", b ? 32'h11 : 32'h22, pixelColour)
                if (frac == style[7:0]) begin
                    frac = 8'h0;
                    idx = (idx == style[12:8]) ? 5'h0 : idx + 5'h1;
                end else begin
                    frac = frac + 8'h1;
                end
                got++;
            end
        end
        `CHK("pixel count", n, got)
        for (int c = 0; c < 50 && busy !== 1'b0; c++) @(negedge clk);
    endtask
    initial begin
        logic [31:0] v;
        int k;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        wr(OFF_MASK, msk);
        wr(OFF_STYLE, style);
        rd(OFF_STYLE, v);
        `CHK("style", style & STYLE_MASK, v)
        rd(OFF_MASK, v);
        `CHK("mask", msk, v)
        wr(OFF_ERR0, 32'h80008123);
        wr(OFF_ERR1, 32'h00007abc);
        rd(OFF_ERR0, v);
        `CHK("err0", 32'h80008123 & ERR_MASK, v)
        `CHK("err0 seed", 17'h18123, {errVerticalUse, errVertical})
        `CHK("err1 seed", 17'h07abc, {errHorizontalUse, errHorizontal})
        wr(OFF_FORE, 32'h11);
        wr(OFF_BACK, 32'h22);
        wr(OFF_SRCPOS, 32'h0);
        wr(OFF_CMD, {28'h0, MODE_LINE});
        idx = style[28:24];
        frac = style[23:16];
        draw(32'h13, 20);
        wr(OFF_ERR0, 32'h00008123);
        rd(OFF_SRCPOS, v);
        `CHK("source after line", 32'h13, v)
        `CHK("err0 use cleared", 1'b0, errVerticalUse)
        rd(OFF_STYLE, v);
        `CHK("leftover position", {3'h0, idx, frac, style[15:0]}, v)
        stall = 1'b1;
        draw(32'h0, 20);
        stall = 1'b0;
        transp = 1'b1;
        wr(OFF_CMD, {15'h0, 1'b1, 12'h0, MODE_LINE});
        wr(OFF_STYLE, style);
        rd(OFF_STATUS, v);
        `CHK("status", 32'h10, v)
        idx = style[28:24];
        frac = style[23:16];
        draw(32'h00090013, 20);
        for (int m = 0; m < 2; m++) begin
            wr(OFF_CMD, {16'h0, 2'b11, 10'h0, m[0] ? MODE_STRETCH : MODE_SCREEN});
            wr(m[0] ? OFF_STRETCH : OFF_LAUNCH, 32'hffffffff);
            for (int c = 0; c < 20 && copyStart !== 1'b1; c++) @(negedge clk);
            `CHK("copy start", 1'b1, copyStart)
            `CHK("copy source", XY_MASK, copySource)
            `CHK("copy order", m[0], copyTopDownLtr)
        end
        wr(OFF_LAYOUT, 32'h4);
        wr(OFF_SRCPOS, 32'h13);
        wr(OFF_EXTENT, 32'h00020008);
        wr(OFF_CMD, {28'h0, MODE_HOST});
        wr(OFF_LAUNCH, hw[0]);
        wr(OFF_LAUNCH, hw[1]);
        k = 0;
        for (int c = 0; c < 100 && k < 2; c++) begin
            @(negedge clk);
            if (hostWordValid === 1'b1) begin
                `CHK("host word", hw[k], hostWord)
                `CHK("host align", 5'h13 + 5'(4 * k), hostAlign)
                k++;
            end
        end
        `CHK("host words", 2, k)
        `CHK("host abort", 1'b0, hostAbort)
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
